/* rtl/csp_map.vh */
// register map, field positions, reset values and encodings for the socket regs
`ifndef CSP_MAP_VH
`define CSP_MAP_VH
`define CSP_OFF_REVISION 12'h800
`define CSP_OFF_STATUS 12'h801
`define CSP_OFF_POWER 12'h802
`define CSP_OFF_SYSCTL 12'h804
`define CSP_REV_RESET 4'h4
`define CSP_REV_COMPAT 4'h2
`define CSP_PWR_RESET 8'h00
`define CSP_BIT_OE 7
`define CSP_BIT_AUTO 5
`define CSP_BIT_SUPPLY 4
`define CSP_VCC_HI 4
`define CSP_VCC_LO 3
`define CSP_COMPAT_WMASK 8'hb3
`define CSP_REV_WMASK 8'h9b
`define CSP_VCC_5V 2'h2
`define CSP_VCC_3V3 2'h3
`define CSP_VPP_OFF 2'h0
`define CSP_VPP_VCC 2'h1
`define CSP_VPP_12V 2'h2
`define CSP_SUP_OFF 2'h0
`define CSP_SUP_5V 2'h1
`define CSP_SUP_3V3 2'h2
`define CSP_PROG_OFF 2'h0
`define CSP_PROG_VCC 2'h1
`define CSP_PROG_12V 2'h2
`endif

/* rtl/csp_sync.v */
// two-flop synchroniser for a bundle of pin levels
`default_nettype none
module csp_sync #(
  parameter WIDTH = 4
) (
  input wire mclk, // system clock
  input wire [WIDTH-1:0] din, // asynchronous pin levels
  output reg [WIDTH-1:0] dout // synchronised levels
);
  reg [WIDTH-1:0] stage;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge mclk) begin
        stage[i] <= din[i];
        dout[i] <= stage[i];
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/csp_regs.v */
// socket status and power-control registers behind an apb slave
// Overview of operation
// - status bit 3 is one while detect pin b is low
// - status bit 2 is one while detect pin a is low
// - memory card: bits 1-0 mirror battery sense b and a
// - io card: bit 1 follows card audio, bit 0 state change
// - power bit 7 enables all card-side outputs, reset zero
// - compat layout: bits 6, 3, 2 read zero
// - compat layout: bit 5 enables automatic switching from card detects
// - compat layout: bit 4 enables vcc, level from system select bit
// - compat layout: vpp field 00 off, 01 vcc, 10 12v, 11 reserved
// - compat layout: vpp ignored while vcc not enabled
// - revision layout: vcc 00/01 off, 10 five, 11 3.3 volts
// - revision layout: vpp 10 is 12v, acted on only with vcc on
// - revision layout: bits 6-5 and 2 read zero, writes ignored
// - marked bits survive bus reset while power events enabled
// - revision field resets 0100b; writing 0010b selects compat layout
`default_nettype none
`include "csp_map.vh"
module csp_regs (
  input wire mclk, // 250 mhz system clock
  input wire rst, // synchronous reset, active high
  input wire global_reset_n, // global reset, low active, synchronous
  input wire bus_reset_n, // bus reset, low active, synchronous
  input wire power_event_enable, // power-management events enabled
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready
  output reg [31:0] prdata, // apb read data
  output wire pslverr, // apb error, unmapped address
  input wire card_detect_pin_a, // card detect a pin, low = card
  input wire card_detect_pin_b, // card detect b pin, low = card
  input wire battery_sense_a, // battery sense a / state change pin
  input wire battery_sense_b, // battery sense b / audio pin
  input wire io_card, // socket configured for an io card
  output reg card_outputs_enable, // gate for card-side outputs
  output reg [1:0] supply_voltage_out, // vcc switch: 0 off,1 5v,2 3.3v
  output reg [1:0] prog_voltage_out, // vpp switch: 0 off,1 vcc,2 12v
  output reg auto_switch_active // automatic detect-driven switching on
);
  wire [4:0] pins_sync;
  wire det_b;
  wire det_a;
  wire card_present;
  wire batt_a;
  wire batt_b;
  wire access;
  wire wr;
  wire rd_ok;
  wire compat;
  wire [7:0] status;
  wire [7:0] power_view;
  wire [7:0] wmask;
  wire marked_clear;
  wire plain_clear;
  wire vcc_on;
  wire io_sync;
  wire detect_b_status;
  wire detect_a_status;
  wire [1:0] battery_level_status;
  wire [11:0] word_addr;
  wire hit_rev;
  wire hit_pwr;
  wire hit_sys;
  wire wr_rev;
  wire wr_pwr;
  wire wr_sys;
  wire rd_setup;
  wire [7:0] rev_view;
  wire [7:0] sysctl_view;
  reg [3:0] compat_revision_field;
  reg [1:0] rev_spare;
  reg card_outputs_en;
  reg auto_power_switch_en;
  reg card_supply_enable;
  reg [1:0] supply_voltage_request;
  reg [1:0] prog_voltage_request;
  reg supply_level_select;
  reg [1:0] next_supply;
  reg [1:0] next_prog;
  reg [31:0] next_rdata;

  // card type is a slow socket-side level; synchronised like the pins
  csp_sync #(
    .WIDTH(5)
  ) u_sync (
    .mclk(mclk),
    .din({io_card, card_detect_pin_b, card_detect_pin_a, battery_sense_b,
          battery_sense_a}),
    .dout(pins_sync)
  );

  assign det_b = pins_sync[3];
  assign det_a = pins_sync[2];
  assign batt_b = pins_sync[1];
  assign batt_a = pins_sync[0];
  assign io_sync = pins_sync[4];
  assign card_present = ~det_a & ~det_b;

  // one wait-free access phase; every register answers in the same cycle.
  // the bank is only flops and small muxes, so wait states buy nothing
  assign access = psel & penable;
  assign pready = access;
  assign wr = access & pwrite;

  // word decode for the error response; byte decode for the write strobes
  assign word_addr = {paddr[11:2], 2'b00};
  assign rd_ok = (word_addr == `CSP_OFF_REVISION) ||
                 (word_addr == `CSP_OFF_SYSCTL);
  // an unmapped word errors and writes nothing
  assign pslverr = access & ~rd_ok;

  // writes use the exact byte address; other bytes of a word are read-only
  assign hit_rev = (paddr == `CSP_OFF_REVISION);
  assign hit_pwr = (paddr == `CSP_OFF_POWER);
  assign hit_sys = (paddr == `CSP_OFF_SYSCTL);
  assign wr_rev = wr & hit_rev;
  assign wr_pwr = wr & hit_pwr;
  assign wr_sys = wr & hit_sys;

  // read data is latched in the setup cycle, so it stands for the access
  assign rd_setup = psel & ~penable & ~pwrite;

  // layout select: only 0010b gives the compat layout; every other value,
  // reserved ones too, keeps the revision layout so that an odd write
  // never exposes fields that the software does not expect
  assign compat = (compat_revision_field == `CSP_REV_COMPAT);

  // detect pins are low when a card is seated
  assign detect_b_status = ~det_b;
  assign detect_a_status = ~det_a;

  // the same two pins carry battery sense on a memory card and audio /
  // state change on an io card, so one mirror serves both card types
  assign battery_level_status = {batt_b, batt_a};

  // power, ready and write-protect bits are not handled here; read zero
  assign status = {4'h0, detect_b_status, detect_a_status,
                   battery_level_status};

  // layout picks which stored fields are visible; fields of the other
  // layout keep their stored value but stay hidden
  assign power_view = compat ?
    {card_outputs_en, 1'b0, auto_power_switch_en, card_supply_enable,
     2'b00, prog_voltage_request} :
    {card_outputs_en, 2'b00, supply_voltage_request, 1'b0,
     prog_voltage_request};

  assign wmask = compat ? `CSP_COMPAT_WMASK : `CSP_REV_WMASK;

  // interface type is hardwired; spare bits are plain storage
  assign rev_view = {2'b10, rev_spare, compat_revision_field};

  // system control: bit 0 level select, bit 1 card type read back
  assign sysctl_view = {6'b000000, io_sync, supply_level_select};

  // marked bits hold across a bus reset while power events are enabled,
  // so a host can keep a card powered through its own bus reset; the
  // compat supply enable is not marked and always falls with bus reset.
  // rst stands for the whole-block reset and clears everything
  assign marked_clear = rst | ~global_reset_n |
                        (~bus_reset_n & ~power_event_enable);
  assign plain_clear = rst | ~global_reset_n | ~bus_reset_n;

  // revision field: only rst or the global reset brings it back to 0100b
  always @(posedge mclk) begin
    if (rst | ~global_reset_n) begin
      compat_revision_field <= `CSP_REV_RESET;
    end else if (wr_rev) begin
      compat_revision_field <= pwdata[3:0];
    end
  end

  // spare bits are kept for software that uses them as scratch
  always @(posedge mclk) begin
    if (rst | ~global_reset_n) begin
      rev_spare <= 2'b00;
    end else if (wr_rev) begin
      rev_spare <= pwdata[5:4];
    end
  end

  // compat-only supply enable; not marked, so any bus reset clears it
  always @(posedge mclk) begin
    if (plain_clear) begin
      card_supply_enable <= 1'b0;
    end else if (wr_pwr && compat) begin
      card_supply_enable <= pwdata[`CSP_BIT_SUPPLY];
    end
  end

  // level select lives outside the power register, in system control
  always @(posedge mclk) begin
    if (plain_clear) begin
      supply_level_select <= 1'b0;
    end else if (wr_sys) begin
      supply_level_select <= pwdata[0];
    end
  end

  // output gate is written in both layouts
  always @(posedge mclk) begin
    if (marked_clear) begin
      card_outputs_en <= 1'b0;
    end else if (wr_pwr) begin
      card_outputs_en <= pwdata[`CSP_BIT_OE] & wmask[`CSP_BIT_OE];
    end
  end

  // auto switching bit exists only in the compat layout
  always @(posedge mclk) begin
    if (marked_clear) begin
      auto_power_switch_en <= 1'b0;
    end else if (wr_pwr && compat) begin
      auto_power_switch_en <= pwdata[`CSP_BIT_AUTO];
    end
  end

  // vcc request field exists only in the revision layout
  always @(posedge mclk) begin
    if (marked_clear) begin
      supply_voltage_request <= `CSP_VPP_OFF;
    end else if (wr_pwr && !compat) begin
      supply_voltage_request <= pwdata[`CSP_VCC_HI:`CSP_VCC_LO];
    end
  end

  // vpp field sits at bits 1-0 in both layouts; reserved codes are stored
  always @(posedge mclk) begin
    if (marked_clear) begin
      prog_voltage_request <= `CSP_VPP_OFF;
    end else if (wr_pwr) begin
      prog_voltage_request <= pwdata[1:0] & wmask[1:0];
    end
  end

  // vcc is on in compat when enabled and, with auto switching, a card sits.
  // auto switching needs both detects, so a half-seated card stays unpowered
  assign vcc_on = compat ?
    (card_supply_enable & (~auto_power_switch_en | card_present)) :
    supply_voltage_request[1];

  // vcc command: compat takes the level from system control
  always @* begin
    next_supply = `CSP_SUP_OFF;
    if (compat) begin
      if (vcc_on) begin
        next_supply = supply_level_select ? `CSP_SUP_3V3 :
                      `CSP_SUP_5V;
      end
    end else begin
      case (supply_voltage_request)
        `CSP_VCC_5V: next_supply = `CSP_SUP_5V;
        `CSP_VCC_3V3: next_supply = `CSP_SUP_3V3;
        default: next_supply = `CSP_SUP_OFF;
      endcase
    end
  end

  // vpp command: never applied while the socket has no vcc
  always @* begin
    next_prog = `CSP_PROG_OFF;
    if (vcc_on) begin
      if (compat) begin
        case (prog_voltage_request)
          `CSP_VPP_VCC: next_prog = `CSP_PROG_VCC;
          `CSP_VPP_12V: next_prog = `CSP_PROG_12V;
          default: next_prog = `CSP_PROG_OFF;
        endcase
      end else if (prog_voltage_request == `CSP_VPP_12V) begin
        next_prog = `CSP_PROG_12V;
      end
    end
  end

  // registered switch commands; rst alone clears them, the fields above
  // fall to their reset values under the other two resets, revision and spare under global only, the marked ones under bus reset only with power events off
  always @(posedge mclk) begin
    if (rst) begin
      card_outputs_enable <= 1'b0;
    end else begin
      card_outputs_enable <= card_outputs_en;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      supply_voltage_out <= `CSP_SUP_OFF;
    end else begin
      supply_voltage_out <= next_supply;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      prog_voltage_out <= `CSP_PROG_OFF;
    end else begin
      prog_voltage_out <= next_prog;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      auto_switch_active <= 1'b0;
    end else begin
      auto_switch_active <= compat & auto_power_switch_en;
    end
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    case (word_addr)
      `CSP_OFF_REVISION: begin
        next_rdata[7:0] = rev_view;
        next_rdata[15:8] = status;
        next_rdata[23:16] = power_view;
        next_rdata[31:24] = 8'h00;
      end
      `CSP_OFF_SYSCTL: begin
        next_rdata[7:0] = sysctl_view;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

/* bench/csp_card_model.sv */
// behavioural card: detect, battery and status pins
`default_nettype none
module csp_card_model (
  input wire logic [1:0] seat, // pins pulled low, b then a
  input wire logic [1:0] sense, // battery or audio/change levels
  input wire logic is_io, // io card inserted
  output logic card_detect_pin_a, // low = seated
  output logic card_detect_pin_b, // low = seated
  output logic battery_sense_a, // sense a
  output logic battery_sense_b, // sense b
  output logic io_card // card type
);
  timeunit 1ns;
  timeprecision 1ps;
  assign {card_detect_pin_b, card_detect_pin_a} = ~seat;
  // empty socket: open pins rest at their pull-up level
  assign {battery_sense_b, battery_sense_a} = seat == 2'h0 ? 2'h3 : sense;
  assign io_card = is_io;
endmodule
`default_nettype wire

/* bench/csp_regs_checker.sv */
// port-level assertions for the socket register block
`default_nettype none
`include "csp_map.vh"
module csp_regs_checker (
  input wire logic mclk, rst, global_reset_n, bus_reset_n,
  input wire logic power_event_enable, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic card_outputs_enable, auto_switch_active,
  input wire logic [1:0] supply_voltage_out, prog_voltage_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic compat_q;
  wire live = global_reset_n && bus_reset_n;
  // layout shadow; only 0010b and 0100b are ever written
  always_ff @(posedge mclk)
    if (rst || !global_reset_n) compat_q <= 1'b0;
    else if (psel && penable && pwrite && paddr == 12'h800 && live)
      compat_q <= pwdata[3:0] == `CSP_REV_COMPAT;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence pwr_wr;
    psel && penable && pwrite && paddr == `CSP_OFF_POWER && live;
  endsequence
  oe_follows_bit_a: assert property (
    pwr_wr |-> ##2 card_outputs_enable == $past(pwdata[7], 2))
    else $error("output enable does not follow bit 7");
  rev_vcc_level_a: assert property (
    pwr_wr ##0 !compat_q && pwdata[4] |-> ##2 supply_voltage_out ==
    ($past(pwdata[3], 2) ? `CSP_SUP_3V3 : `CSP_SUP_5V))
    else $error("vcc level wrong in revision layout");
  rev_vpp_gate_a: assert property (
    pwr_wr ##0 !compat_q && !pwdata[4] |-> ##2 prog_voltage_out == 2'h0)
    else $error("vpp applied without vcc");
  compat_vpp_gate_a: assert property (
    pwr_wr ##0 compat_q && !pwdata[4] |-> ##2 prog_voltage_out == 2'h0)
    else $error("compat vpp applied without vcc");
  compat_vcc_off_a: assert property (
    pwr_wr ##0 compat_q && !pwdata[4] |-> ##2 supply_voltage_out == 2'h0)
    else $error("compat vcc on with bit 4 clear");
  auto_switch_a: assert property (
    pwr_wr |-> ##2 auto_switch_active == $past(compat_q && pwdata[5], 2))
    else $error("auto switching state wrong");
  bus_reset_clr_a: assert property (
    !bus_reset_n && !power_event_enable && global_reset_n |-> ##2
    !card_outputs_enable && supply_voltage_out == 2'h0)
    else $error("bus reset left power bits");
  global_reset_clr_a: assert property (
    !global_reset_n |-> ##2 !card_outputs_enable && !auto_switch_active)
    else $error("global reset left power bits");
endmodule
bind csp_regs csp_regs_checker chk_u (
  .mclk(mclk),
  .rst(rst),
  .global_reset_n(global_reset_n),
  .bus_reset_n(bus_reset_n),
  .power_event_enable(power_event_enable),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .card_outputs_enable(card_outputs_enable),
  .auto_switch_active(auto_switch_active),
  .supply_voltage_out(supply_voltage_out),
  .prog_voltage_out(prog_voltage_out)
);
`default_nettype wire

/* bench/card_socket_status_power_regs_bench.sv */
// register-level tests for the socket status and power block
`default_nettype none
module card_socket_status_power_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, global_reset_n = 1, bus_reset_n = 1;
  logic power_event_enable = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, card_detect_pin_a, card_detect_pin_b;
  logic battery_sense_a, battery_sense_b, io_card, is_io = 0;
  logic card_outputs_enable, auto_switch_active;
  logic [1:0] supply_voltage_out, prog_voltage_out, seat = 0, sense = 0;
  logic [3:0] rv, sy;
  logic [7:0] wd, ep;
  logic [1:0] es, eq;
  // rev, sysctl, written byte, stored byte, vcc, vpp
  logic [27:0] tbl [7] = '{28'h40ff9b8, 28'h4092926, 28'h400a0a0,
    28'h20f1b15, 28'h2022220, 28'h211212a, 28'h210b030};
  int n_errors = 0, num_checks = 0, cyc = 0;
  csp_regs dut_u (
    .mclk(mclk),
    .rst(rst),
    .global_reset_n(global_reset_n),
    .bus_reset_n(bus_reset_n),
    .power_event_enable(power_event_enable),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .card_detect_pin_a(card_detect_pin_a),
    .card_detect_pin_b(card_detect_pin_b),
    .battery_sense_a(battery_sense_a),
    .battery_sense_b(battery_sense_b),
    .io_card(io_card),
    .card_outputs_enable(card_outputs_enable),
    .supply_voltage_out(supply_voltage_out),
    .prog_voltage_out(prog_voltage_out),
    .auto_switch_active(auto_switch_active)
  );
  csp_card_model card_u (
    .seat(seat),
    .sense(sense),
    .is_io(is_io),
    .card_detect_pin_a(card_detect_pin_a),
    .card_detect_pin_b(card_detect_pin_b),
    .battery_sense_a(battery_sense_a),
    .battery_sense_b(battery_sense_b),
    .io_card(io_card)
  );
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 3000) begin
    n_errors++;
    summarize();
  end
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      seat <= i[1:0];
      sense <= 2'(3 - i);
      is_io <= i[0];
      repeat (4) @(posedge mclk);
      xfer(0, 12'h800, 8'h0);
      chk({rd[23:16], rd[7:0]}, 16'h0084);
      chk(rd[15:8],
        {4'h0, i[1:0], i ? 2'(3 - i) : 2'h3});
    end
    foreach (tbl[k]) begin
      {rv, sy, wd, ep, es, eq} = tbl[k];
      xfer(1, 12'h800, {4'h0, rv});
      xfer(1, 12'h804, {4'h0, sy});
      xfer(1, 12'h802, wd);
      xfer(0, 12'h800, 8'h0);
      chk({rd[23:16], rd[7:0]},
        {ep, 4'h8, rv});
      chk({card_outputs_enable, auto_switch_active,
        supply_voltage_out, prog_voltage_out},
        {ep[7], rv == 4'h2 && ep[5], es, eq});
    end
    xfer(0, 12'h804, 8'h0);
    chk(rd[1:0], 2'h3);
    xfer(1, 12'h802, 8'h30);
    seat <= 2'h0;
    repeat (4) @(posedge mclk);
    chk(supply_voltage_out, 2'h0);
    seat <= 2'h3;
    repeat (4) @(posedge mclk);
    chk(supply_voltage_out, 2'h2);
    xfer(0, 12'h808, 8'h0);
    chk(err, 1'b1);
    for (int j = 0; j < 3; j++) begin
      xfer(1, 12'h802, 8'h91);
      power_event_enable <= j == 0;
      bus_reset_n <= j == 2;
      global_reset_n <= j != 2;
      @(posedge mclk);
      bus_reset_n <= 1'b1;
      global_reset_n <= 1'b1;
      xfer(0, 12'h800, 8'h0);
      chk({rd[23:16], rd[7:0]},
        {j ? 8'h00 : 8'h81, j == 2 ? 8'h84 : 8'h82});
    end
    summarize();
  end
endmodule
`default_nettype wire
